//--- design/pce_ctrl.sv
// Performance monitor count-enable, overflow, software increment and pointer group.
// Assumes a core issuing coprocessor register transfers on i_clk, one per cycle at most,
// and that the counters, event selection and global control live elsewhere in the unit.
`timescale 1ns/1ps
`include "pce_map.svh"

module pce_ctrl (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	// Coprocessor transfer from the core
	input  wire logic        i_cp_valid,
	input  wire logic        i_cp_write,
	input  wire logic [3:0]  i_cp_num,
	input  wire logic [2:0]  i_cp_opc1,
	input  wire logic [3:0]  i_cp_crn,
	input  wire logic [3:0]  i_cp_crm,
	input  wire logic [2:0]  i_cp_opc2,
	input  wire logic [31:0] i_cp_wdata,
	input  wire logic        i_cp_user,
	// User-enable control from the rest of the unit
	input  wire logic        i_user_enable,
	// Global enable and per-counter event codes from the rest of the unit
	input  wire logic        i_global_enable,
	input  wire logic [7:0]  i_event_sel0,
	input  wire logic [7:0]  i_event_sel1,
	// Overflow events from the counters: bit 2 cycle, bits 1..0 event counters
	input  wire logic [2:0]  i_overflow,
	// Transfer answer to the core
	output logic             o_cp_ack,
	output logic             o_cp_undef,
	output logic [31:0]      o_cp_rdata,
	// Controls to the counters
	output logic [2:0]       o_count_enable,
	output logic [1:0]       o_sw_increment,
	output logic [4:0]       o_counter_pointer
);

	typedef struct packed {
		logic        ack;
		logic        undef;
		logic [31:0] rdata;
		logic [2:0]  count_enable;
		logic [1:0]  sw_increment;
		logic [4:0]  pointer;
		logic [2:0]  en;
	} pce_state_t;

	pce_state_t       state;
	pce_state_t       next_state;
	pce_pkg::pce_sel_t sel;
	logic             hit;
	logic             allowed;
	pce_pkg::pce_vec_t wvec;
	pce_pkg::pce_vec_t ovf_clr;
	pce_pkg::pce_vec_t ovf_flags;
	logic [31:0]      en_word;
	logic [31:0]      ovf_word;

	// Fold a 32-bit register word onto the three implemented bit positions
	function automatic logic [2:0] pce_pick(input logic [31:0] w);
		pce_pick = {w[`PCE_BIT_CYC], w[`PCE_BIT_C1], w[`PCE_BIT_C0]};
	endfunction

	// Spread the three implemented bits back to their word positions
	function automatic logic [31:0] pce_spread(input logic [2:0] v);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`PCE_BIT_CYC] = v[2];
		w[`PCE_BIT_C1]  = v[1];
		w[`PCE_BIT_C0]  = v[0];
		pce_spread = w;
	endfunction

	// Decode the transfer; the group is one shared copy for both security states
	always_comb begin
		hit = i_cp_valid && (i_cp_num == `PCE_CP_NUM) && (i_cp_opc1 == `PCE_OPC1)
			&& (i_cp_crn == `PCE_CRN) && (i_cp_crm == `PCE_CRM);
		case (i_cp_opc2)
			`PCE_OP2_ENSET: sel = pce_pkg::PCE_SEL_ENSET;
			`PCE_OP2_ENCLR: sel = pce_pkg::PCE_SEL_ENCLR;
			`PCE_OP2_OVF:   sel = pce_pkg::PCE_SEL_OVF;
			`PCE_OP2_SWINC: sel = pce_pkg::PCE_SEL_SWINC;
			`PCE_OP2_PTR:   sel = pce_pkg::PCE_SEL_PTR;
			default:        sel = pce_pkg::PCE_SEL_NONE;
		endcase
		if (!hit) begin
			sel = pce_pkg::PCE_SEL_NONE;
		end
		// User mode may reach the group only when user access is enabled
		allowed = !i_cp_user || i_user_enable;
	end

	// Reserved bits 30..2 are simply never looked at, so writes there vanish
	assign wvec = pce_pick(i_cp_wdata);

	// Overflow flags clear on a written one; a counter overflow in the same cycle wins
	assign ovf_clr = (sel == pce_pkg::PCE_SEL_OVF && i_cp_write && allowed)
		? wvec : 3'h0;

	pce_flag_bank #(
		.WIDTH (3)
	) u_ovf (
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.i_set   (i_overflow),
		.i_clr   (ovf_clr),
		.o_flags (ovf_flags)
	);

	// Read views; bits that do not exist read as zero
	assign en_word  = pce_spread(state.en);
	assign ovf_word = pce_spread(ovf_flags);

	// Next-state logic for enables, pointer, increments and the answer
	always_comb begin
		next_state = state;
		next_state.ack = 1'b0;
		next_state.undef = 1'b0;
		next_state.sw_increment = 2'b00;
		if (sel != pce_pkg::PCE_SEL_NONE) begin
			next_state.ack = 1'b1;
			next_state.undef = !allowed;
			next_state.rdata = 32'h0000_0000;
			if (allowed && i_cp_write) begin
				case (sel)
					pce_pkg::PCE_SEL_ENSET: begin
						next_state.en = state.en | wvec;
					end
					pce_pkg::PCE_SEL_ENCLR: begin
						next_state.en = state.en & ~wvec;
					end
					pce_pkg::PCE_SEL_SWINC: begin
						// Only counters set to the software event take the pulse
						next_state.sw_increment[0] = wvec[0]
							&& (i_event_sel0 == `PCE_EVT_SWINC);
						next_state.sw_increment[1] = wvec[1]
							&& (i_event_sel1 == `PCE_EVT_SWINC);
					end
					pce_pkg::PCE_SEL_PTR: begin
						// Undefined codes are stored as written; the far side treats them freely
						next_state.pointer = i_cp_wdata[`PCE_PTR_MSB:0];
					end
					default: begin
						next_state.en = state.en;
					end
				endcase
			end else if (allowed) begin
				case (sel)
					pce_pkg::PCE_SEL_ENSET: next_state.rdata = en_word;
					pce_pkg::PCE_SEL_ENCLR: next_state.rdata = en_word;
					pce_pkg::PCE_SEL_OVF:   next_state.rdata = ovf_word;
					pce_pkg::PCE_SEL_PTR: begin
						next_state.rdata = {27'h0000000, state.pointer};
					end
					// Write-only register reads back zero
					default:                next_state.rdata = 32'h0000_0000;
				endcase
			end
		end
		// Effective enables use the updated per-counter bits; stored bits survive global off
		next_state.count_enable = i_global_enable ? next_state.en : 3'h0;
	end

	// State register, synchronous active-low reset
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			state <= '0;
			state.en <= `PCE_RST_EN;
			state.pointer <= `PCE_RST_PTR;
		end else begin
			state <= next_state;
		end
	end

	// All outputs straight from the state register
	assign o_cp_ack          = state.ack;
	assign o_cp_undef        = state.undef;
	assign o_cp_rdata        = state.rdata;
	assign o_count_enable    = state.count_enable;
	assign o_sw_increment    = state.sw_increment;
	assign o_counter_pointer = state.pointer;

endmodule

//--- design/pce_flag_bank.sv
// Set/clear bank of sticky bits with hardware-set priority over software clear.
// Assumes all inputs are synchronous to i_clk.
`timescale 1ns/1ps
`include "pce_map.svh"

module pce_flag_bank #(
	parameter int WIDTH = 3
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst_b,
	// Set and clear requests, one bit per flag
	input  wire logic [WIDTH-1:0] i_set,
	input  wire logic [WIDTH-1:0] i_clr,
	// Stored flags
	output logic      [WIDTH-1:0] o_flags
);

	// Elaboration-time refusal of a width the bank cannot hold
	if (WIDTH < 1) begin : g_bad_width
		$error("pce_flag_bank: WIDTH must be at least 1");
	end

	typedef struct packed {
		logic [WIDTH-1:0] flags;
	} pce_fb_state_t;

	pce_fb_state_t state;
	pce_fb_state_t next_state;

	// Set wins over clear so an event landing with the clear is not lost
	always_comb begin
		next_state = state;
		next_state.flags = (state.flags & ~i_clr) | i_set;
	end

	// Registered state, synchronous active-low reset
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign o_flags = state.flags;

endmodule

//--- design/pce_map.svh
// Register map constants for the performance counter enable/control group.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef PCE_MAP_SVH
`define PCE_MAP_SVH

// Coprocessor transfer decode: coprocessor number, CRn, CRm, opc1
`define PCE_CP_NUM          4'hF
`define PCE_CRN             4'h9
`define PCE_CRM             4'hC
`define PCE_OPC1            3'h0
// opcode2 selects the register inside the group
`define PCE_OP2_ENSET       3'h1
`define PCE_OP2_ENCLR       3'h2
`define PCE_OP2_OVF         3'h3
`define PCE_OP2_SWINC       3'h4
`define PCE_OP2_PTR         3'h5
// Field positions
`define PCE_BIT_CYC         31
`define PCE_BIT_C1          1
`define PCE_BIT_C0          0
`define PCE_PTR_MSB         4
// Pointer codes
`define PCE_PTR_C0          5'h00
`define PCE_PTR_C1          5'h01
`define PCE_PTR_FILT        5'h1F
// Event code that lets software increments through
`define PCE_EVT_SWINC       8'h00
// Reset values
`define PCE_RST_EN          3'h0
`define PCE_RST_OVF         3'h0
`define PCE_RST_PTR         5'h00

`endif

//--- design/pce_pkg.sv
// Types for the performance counter enable/control group.
// Assumes pce_map.svh is available on the include path.
package pce_pkg;

	// Access decode result for one coprocessor transfer
	typedef enum logic [2:0] {
		PCE_SEL_NONE,
		PCE_SEL_ENSET,
		PCE_SEL_ENCLR,
		PCE_SEL_OVF,
		PCE_SEL_SWINC,
		PCE_SEL_PTR
	} pce_sel_t;

	// Three-bit compact vector: bit 2 cycle counter, bits 1..0 event counters
	typedef logic [2:0] pce_vec_t;

endpackage

//--- verification/pce_core_model.sv
// Core-side model issuing coprocessor register transfers to the group.
// Assumes the block answers a taken transfer with a one-cycle ack.
`timescale 1ns/1ps
module pce_core_model (
	input  wire logic        i_clk,
	input  wire logic        i_ack,
	input  wire logic        i_undef,
	input  wire logic [31:0] i_rdata,
	output logic             o_valid,
	output logic             o_write,
	output logic [3:0]       o_num,
	output logic [2:0]       o_opc1,
	output logic [3:0]       o_crn,
	output logic [3:0]       o_crm,
	output logic [2:0]       o_opc2,
	output logic [31:0]      o_wdata,
	output logic             o_user
);
	// Idle bus at time zero
	initial begin
		{o_valid, o_write, o_opc1, o_opc2, o_user} = '0;
		{o_num, o_crn, o_crm, o_wdata} = '0;
	end
	// One transfer; number, opc1 and CRn are this group's codes, CRm and opcode2 come from the caller
	task automatic xfer(input logic w, input logic [2:0] op, input logic [31:0] d,
		input logic u, input logic [3:0] crm, output logic ok,
		output logic [31:0] rd, output logic ud);
		{ok, rd, ud} = '0;
		@(posedge i_clk) #2;
		{o_valid, o_write, o_num, o_opc1, o_crn} = {1'b1, w, 4'hF, 3'h0, 4'h9};
		{o_crm, o_opc2, o_wdata, o_user} = {crm, op, d, u};
		@(posedge i_clk) #2;
		// Released fields flip so a stale value never looks valid
		{o_valid, o_wdata, o_opc2, o_crm} = {1'b0, ~d, ~op, ~crm};
		repeat (3) if (!ok) begin
			if (i_ack === 1'b1) {ok, rd, ud} = {1'b1, i_rdata, i_undef};
			else @(posedge i_clk) #2;
		end
	endtask
endmodule

//--- verification/pce_ctrl_sva.sv
// Port-level assertions for the enable, flag, increment and pointer group.
// Assumes it is bound into pce_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module pce_ctrl_sva (
	input wire logic        i_clk, i_rst_b, i_cp_valid, i_cp_write, i_cp_user,
	input wire logic        i_user_enable, i_global_enable, o_cp_ack, o_cp_undef,
	input wire logic [3:0]  i_cp_num, i_cp_crn, i_cp_crm,
	input wire logic [2:0]  i_cp_opc1, i_cp_opc2, i_overflow, o_count_enable,
	input wire logic [7:0]  i_event_sel0, i_event_sel1,
	input wire logic [31:0] i_cp_wdata, o_cp_rdata,
	input wire logic [1:0]  o_sw_increment,
	input wire logic [4:0]  o_counter_pointer
);
	logic hit;
	logic ref_u;
	logic [2:0] wv;
	// Decode kept apart from the design so a decode slip is visible
	assign hit = i_cp_valid && i_cp_num == 4'hF && i_cp_opc1 == 3'h0 && i_cp_crn == 4'h9
		&& i_cp_crm == 4'hC && i_cp_opc2 inside {[3'h1:3'h5]};
	assign ref_u = i_cp_user && !i_user_enable;
	assign wv = {i_cp_wdata[31], i_cp_wdata[1:0]};
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	a_ack_follows: assert property (hit |=> o_cp_ack) else $error("no ack");
	a_no_stray: assert property (!hit |=> !o_cp_ack) else $error("stray ack");
	a_set_bits: assert property (hit && i_cp_write && i_cp_opc2 == 3'h1 && !ref_u &&
		i_global_enable |=> (o_count_enable & $past(wv)) == $past(wv))
		else $error("set failed");
	a_clear_bits: assert property (hit && i_cp_write && i_cp_opc2 == 3'h2 && !ref_u
		|=> (o_count_enable & $past(wv)) == 3'h0) else $error("clear failed");
	a_global_off: assert property (!i_global_enable |=> o_count_enable == 3'h0)
		else $error("counting while off");
	a_rsvd_zero: assert property (o_cp_rdata[30:5] == 26'h0) else $error("rsvd");
	a_enable_read: assert property (hit && !i_cp_write && i_cp_opc2 inside {3'h1, 3'h2}
		&& !ref_u && i_global_enable && $past(i_global_enable) |=> o_cp_rdata ==
		{$past(o_count_enable[2]), 29'h0, $past(o_count_enable[1:0])})
		else $error("enable read");
	a_user_refuse: assert property (hit && ref_u |=> o_cp_undef && o_cp_rdata == 32'h0)
		else $error("not refused");
	a_inc_gate: assert property (hit && i_cp_write && i_cp_opc2 == 3'h4 && !ref_u |=>
		o_sw_increment == ($past(i_cp_wdata[1:0]) & {$past(i_event_sel1) == 8'h00,
		$past(i_event_sel0) == 8'h00})) else $error("increment");
	a_ptr_write: assert property (hit && i_cp_write && i_cp_opc2 == 3'h5 && !ref_u
		|=> o_counter_pointer == $past(i_cp_wdata[4:0])) else $error("pointer");
	c_refused: cover property (hit && ref_u);
	c_increment: cover property (o_sw_increment != 2'h0);
	c_pointer: cover property (hit && i_cp_write && i_cp_opc2 == 3'h5);
endmodule
bind pce_ctrl pce_ctrl_sva i_pce_ctrl_sva (.*);

//--- verification/testbench.sv
// Self-checking bench for pce_ctrl with a core model driving transfers.
// Assumes pce_ctrl and pce_core_model are compiled alongside.
`timescale 1ns/1ps
module testbench;
	logic i_clk = 0, i_rst_b = 0, i_user_enable = 1, i_global_enable = 1, ok, ud;
	logic i_cp_valid, i_cp_write, i_cp_user, o_cp_ack, o_cp_undef;
	logic [7:0] i_event_sel0 = 8'h00, i_event_sel1 = 8'h05;
	logic [2:0] i_overflow = 3'h0, i_cp_opc1, i_cp_opc2, o_count_enable;
	logic [3:0] i_cp_num, i_cp_crn, i_cp_crm;
	logic [31:0] i_cp_wdata, o_cp_rdata, rd;
	logic [1:0] o_sw_increment;
	logic [4:0] o_counter_pointer;
	logic [4:0] ptr [3] = '{5'h01, 5'h1F, 5'h00};
	int err_count = 0, checked = 0;
	pce_ctrl i_pce_ctrl (.*);
	pce_core_model i_pce_core_model (.i_clk(i_clk), .i_ack(o_cp_ack), .i_undef(o_cp_undef),
		.i_rdata(o_cp_rdata), .o_valid(i_cp_valid), .o_write(i_cp_write), .o_num(i_cp_num),
		.o_opc1(i_cp_opc1), .o_crn(i_cp_crn), .o_crm(i_cp_crm), .o_opc2(i_cp_opc2),
		.o_wdata(i_cp_wdata), .o_user(i_cp_user));
	// Compare and verdict
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		if (err_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Transfer with a missing ack treated as a hang
	task automatic acc(input logic w, input logic [2:0] op, input logic [31:0] d,
		input logic u);
		i_pce_core_model.xfer(w, op, d, u, 4'hC, ok, rd, ud);
		chk({31'h0, ok}, 32'h1);
		if (!ok) report_and_stop;
	endtask
	initial forever #12.5 i_clk = ~i_clk;
	initial begin
		repeat (8) @(posedge i_clk);
		#2 i_rst_b = 1;
		acc(0, 3'h1, 0, 0);
		chk(rd, 32'h0);
		acc(1, 3'h1, 32'hFFFFFFFF, 0);
		chk({29'h0, o_count_enable}, 32'h7);
		acc(0, 3'h1, 0, 0);
		chk(rd, 32'h80000003);
		acc(1, 3'h2, 32'h00000002, 0);
		acc(0, 3'h2, 0, 0);
		chk(rd, 32'h80000001);
		// Enables must survive a global disable
		i_global_enable = 0;
		@(posedge i_clk) #2;
		chk({29'h0, o_count_enable}, 32'h0);
		acc(0, 3'h1, 0, 0);
		chk(rd, 32'h80000001);
		i_global_enable = 1;
		@(posedge i_clk) #2;
		chk({29'h0, o_count_enable}, 32'h5);
		i_overflow = 3'h7;
		@(posedge i_clk) #2 i_overflow = 3'h0;
		acc(0, 3'h3, 0, 0);
		chk(rd, 32'h80000003);
		acc(1, 3'h3, 32'h80000001, 0);
		acc(0, 3'h3, 0, 0);
		chk(rd, 32'h00000002);
		acc(1, 3'h4, 32'h00000003, 0);
		chk({30'h0, o_sw_increment}, 32'h1);
		// Only the three defined pointer codes are programmed
		foreach (ptr[k]) begin
			acc(1, 3'h5, {27'h0, ptr[k]}, 0);
			chk({27'h0, o_counter_pointer}, {27'h0, ptr[k]});
			acc(0, 3'h5, 0, 0);
			chk(rd, {27'h0, ptr[k]});
		end
		i_user_enable = 0;
		acc(1, 3'h1, 32'h2, 1);
		chk({31'h0, ud}, 32'h1);
		acc(0, 3'h1, 0, 0);
		chk(rd, 32'h80000001);
		i_pce_core_model.xfer(0, 3'h1, 0, 0, 4'hB, ok, rd, ud);
		chk({31'h0, ok}, 32'h0);
		report_and_stop;
	end
endmodule
